/* File: verilog/gpc_pkg.sv */
/*
  gpc_pkg: constants and types shared by the gigabit physical-side
  adapter and its receive FIFO.
  Assumes a single system clock of 50 MHz sampling every link pin.
*/
package gpc_pkg;

  // clock figures
  localparam int GPC_CLK_MHZ = 50;
  localparam int GPC_TX_REF_MHZ = 125;

  // stream widths and buffer sizing
  localparam int GPC_DATA_W = 8;
  localparam int GPC_FIFO_DEPTH = 16;

  // receive word layout inside the FIFO: {last, err, data}
  localparam int GPC_RXW_ERR = 8;
  localparam int GPC_RXW_LAST = 9;
  localparam int GPC_RXW_W = 10;

  // forwarded clock: system cycles per half period, default figure
  localparam int GPC_TX_HALF = 1;

  // receive input delay line: longest setting and default setting
  localparam int GPC_RX_DLY_MAX = 4;
  localparam int GPC_RX_DLY_DEF = 0;

  // reset values
  localparam logic [7:0] GPC_TXD_RST = 8'h00;
  localparam logic [9:0] GPC_RXW_RST = 10'h000;

  // transmit sequencer states
  typedef enum logic [1:0] {
    GPC_TX_IDLE = 2'b00,
    GPC_TX_SEND = 2'b01,
    GPC_TX_DRAIN = 2'b10
  } gpc_tx_state_t;

endpackage

/* File: verilog/gpc_fifo.sv */
/*
  gpc_fifo: flip-flop FIFO with valid/ready on both sides and a
  registered output stage.
  Assumes writer and reader share one clock and one clock enable.
*/
`timescale 1ns/100ps
module gpc_fifo import gpc_pkg::*; #(
  parameter int WIDTH = GPC_RXW_W,
  parameter int DEPTH = GPC_FIFO_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic reset_n, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [WIDTH-1:0] in_data, // write word
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  output logic [WIDTH-1:0] out_data, // registered read word
  output logic out_valid, // read word present
  input wire logic out_ready // reader takes word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // refuse shapes the pointer logic cannot serve
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("gpc_fifo: depth must be a power of two, width positive");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] cnt;
    logic [WIDTH-1:0] odata;
    logic ovalid;
  } gpc_fifo_state_t;

  gpc_fifo_state_t st_ff;
  gpc_fifo_state_t nxt_st;
  logic do_wr;
  logic do_rd;

  // honest full: ready only while storage has a free slot
  assign in_ready = (st_ff.cnt < (AW+1)'(DEPTH));
  assign out_data = st_ff.odata;
  assign out_valid = st_ff.ovalid;

  // next state: write, move head into output stage, count
  always_comb begin
    nxt_st = st_ff;
    do_wr = in_valid && in_ready;
    do_rd = (st_ff.cnt != '0) && (!st_ff.ovalid || out_ready);
    if (do_wr) begin
      nxt_st.mem[st_ff.wptr] = in_data;
      nxt_st.wptr = st_ff.wptr + 1'b1;
    end
    if (st_ff.ovalid && out_ready) begin
      nxt_st.ovalid = 1'b0;
    end
    if (do_rd) begin
      nxt_st.odata = st_ff.mem[st_ff.rptr];
      nxt_st.ovalid = 1'b1;
      nxt_st.rptr = st_ff.rptr + 1'b1;
    end
    if (do_wr && !do_rd) begin
      nxt_st.cnt = st_ff.cnt + 1'b1;
    end else if (do_rd && !do_wr) begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

endmodule // gpc_fifo

/* File: verilog/gpc_gmii_phy_side.sv */
/*
  gpc_gmii_phy_side: physical-side adapter between a byte stream and
  an external gigabit PHY over the byte-wide media interface.
  Assumes clk is the transmit reference feeding this block and the
  user transmit logic, and that every PHY pin, including the PHY
  receive clock, is asynchronous and sampled here.
*/
// Summary of operation
// - every transmit data and control pin is driven straight from a final register.
// - the forwarded transmit clock comes from a register updated with the data.
// - the forwarded clock is inverted so its rising edge sits mid data period.
// - collision and carrier sense are treated as asynchronous and registered on entry.
// - receive data and control are sampled on the PHY receive clock rising edges.
// - a build-time delay setting moves the receive sampling point.
// - the PLL receive variant refuses half duplex and runs full duplex.
// - in the PLL receive variant the receiver goes inactive without lock.
// - several instances may share one transmit reference clock.
// - each instance has its own receive clock, never shared.
`timescale 1ns/100ps
module gpc_gmii_phy_side import gpc_pkg::*; #(
  parameter int TX_HALF = GPC_TX_HALF,
  parameter int RX_DELAY = GPC_RX_DLY_DEF,
  parameter bit PLL_RX = 1'b0,
  parameter int FIFO_DEPTH = GPC_FIFO_DEPTH
) (
  input wire logic clk, // transmit reference, shared
  input wire logic reset_n, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic half_duplex, // half duplex requested
  input wire logic [7:0] tx_data, // user transmit byte
  input wire logic tx_valid, // user byte present
  input wire logic tx_last, // last byte of frame
  output logic tx_ready, // byte taken this cycle
  output logic [7:0] gmii_txd, // transmit data pins
  output logic gmii_tx_en, // transmit enable pin
  output logic gmii_tx_er, // transmit error pin
  output logic gmii_tx_clk, // forwarded transmit clock
  input wire logic gmii_col, // collision pin, async
  input wire logic gmii_crs, // carrier sense pin, async
  output logic col_seen, // collision, synchronised
  output logic crs_seen, // carrier, synchronised
  input wire logic gmii_rx_clk, // PHY receive clock pin
  input wire logic [7:0] gmii_rxd, // receive data pins
  input wire logic gmii_rx_dv, // receive data valid pin
  input wire logic gmii_rx_er, // receive error pin
  input wire logic rx_pll_locked, // receive PLL lock, async
  output logic [7:0] rx_data, // user receive byte
  output logic rx_err, // byte carried an error
  output logic rx_last, // last byte of frame
  output logic rx_valid, // receive byte present
  input wire logic rx_ready, // user takes receive byte
  output logic rx_active, // receiver running
  output logic rx_overflow, // byte lost, one cycle
  output logic hd_refused // half duplex refused
);

  localparam int DLY_N = GPC_RX_DLY_MAX + 1;

  // refuse settings the logic cannot serve
  generate
    if (TX_HALF < 1 || RX_DELAY < 0 || RX_DELAY > GPC_RX_DLY_MAX) begin : g_chk
      $error("gpc_gmii_phy_side: bad forwarded clock or delay setting");
    end
  endgenerate

  typedef struct packed {
    // transmit side
    logic [15:0] phase;
    logic tclk;
    logic [7:0] txd;
    logic tx_en;
    logic tx_er;
    logic tx_rdy;
    logic [7:0] hold_d;
    logic hold_last;
    logic hold_vld;
    gpc_tx_state_t tst;
    logic col_m;
    logic col_s;
    logic crs_m;
    logic crs_s;
    // receive side
    logic rclk_m;
    logic rclk_s;
    logic rclk_d;
    logic [GPC_RXW_W-1:0] rxw_m;
    logic [GPC_RXW_W-1:0] rxw_s;
    logic [DLY_N-1:0][GPC_RXW_W-1:0] dly;
    logic lock_m;
    logic lock_s;
    logic [7:0] pend_d;
    logic pend_er;
    logic pend_vld;
    logic push;
    logic [GPC_RXW_W-1:0] push_w;
    logic ovf;
    logic ract;
    logic hd_ref;
  } gpc_state_t;

  gpc_state_t st_ff;
  gpc_state_t nxt_st;
  logic fifo_in_ready;
  logic [GPC_RXW_W-1:0] fifo_out_data;
  logic fifo_out_valid;
  logic hd_eff;
  logic slot_end;
  logic rclk_rise;
  logic [GPC_RXW_W-1:0] rx_sample;
  logic lock_ok;

  // pack a receive word for the FIFO
  function automatic logic [GPC_RXW_W-1:0] rx_word(input logic [7:0] d,
      input logic er, input logic last);
    rx_word = {last, er, d};
  endfunction

  // transmit outputs straight from the final registers
  assign gmii_txd = st_ff.txd;
  assign gmii_tx_en = st_ff.tx_en;
  assign gmii_tx_er = st_ff.tx_er;
  assign gmii_tx_clk = st_ff.tclk;
  assign tx_ready = st_ff.tx_rdy;
  assign col_seen = st_ff.col_s;
  assign crs_seen = st_ff.crs_s;
  assign rx_active = st_ff.ract;
  assign rx_overflow = st_ff.ovf;
  assign hd_refused = st_ff.hd_ref;

  // receive buffer output, registered inside the FIFO
  assign rx_data = fifo_out_data[7:0];
  assign rx_err = fifo_out_data[GPC_RXW_ERR];
  assign rx_last = fifo_out_data[GPC_RXW_LAST];
  assign rx_valid = fifo_out_valid;

  // decoded terms used by the next-state logic
  always_comb begin
    // PLL receive variant runs full duplex only
    hd_eff = half_duplex && !PLL_RX;
    slot_end = (st_ff.phase == 16'(2 * TX_HALF - 1));
    // edge found from the second synchroniser stage onward
    rclk_rise = st_ff.rclk_s && !st_ff.rclk_d;
    rx_sample = st_ff.dly[RX_DELAY];
    lock_ok = !PLL_RX || st_ff.lock_s;
  end

  // next state of the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tx_rdy = 1'b0;
    nxt_st.push = 1'b0;
    nxt_st.ovf = 1'b0;

    // pin synchronisers, two stages each
    nxt_st.col_m = gmii_col;
    nxt_st.col_s = st_ff.col_m;
    nxt_st.crs_m = gmii_crs;
    nxt_st.crs_s = st_ff.crs_m;
    nxt_st.rclk_m = gmii_rx_clk;
    nxt_st.rclk_s = st_ff.rclk_m;
    nxt_st.rclk_d = st_ff.rclk_s;
    nxt_st.rxw_m = {1'b0, gmii_rx_er, gmii_rxd};
    nxt_st.rxw_m[GPC_RXW_LAST] = gmii_rx_dv;
    nxt_st.rxw_s = st_ff.rxw_m;
    nxt_st.lock_m = rx_pll_locked;
    nxt_st.lock_s = st_ff.lock_m;
    nxt_st.hd_ref = half_duplex && PLL_RX;

    // input delay line, tap chosen at build time
    nxt_st.dly[0] = st_ff.rxw_s;
    for (int i = 1; i < DLY_N; i++) begin
      nxt_st.dly[i] = st_ff.dly[i-1];
    end

    // forwarded clock: low in first half of a slot, so it rises mid data
    if (slot_end) begin
      nxt_st.phase = '0;
    end else begin
      nxt_st.phase = st_ff.phase + 16'h0001;
    end
    nxt_st.tclk = (nxt_st.phase >= 16'(TX_HALF));

    // offer one take per slot, on the cycle before the slot ends
    if (st_ff.phase == 16'(2 * TX_HALF - 2) || (TX_HALF == 1 && slot_end
        && 1'b0)) begin
      nxt_st.tx_rdy = 1'b1;
    end

    // pins change at the slot boundary, with the clock falling;
    // a byte taken in this same cycle refills the hold stage below
    if (slot_end) begin
      nxt_st.txd = st_ff.hold_vld ? st_ff.hold_d : GPC_TXD_RST;
      nxt_st.tx_en = st_ff.hold_vld;
      nxt_st.tx_er = (st_ff.tst == GPC_TX_DRAIN) && st_ff.tx_en;
      nxt_st.hold_vld = 1'b0;
    end

    // transmit sequencer
    case (st_ff.tst)
      GPC_TX_IDLE: begin
        // half duplex defers while carrier is present
        if (tx_valid && st_ff.tx_rdy && !(hd_eff && st_ff.crs_s)) begin
          nxt_st.hold_d = tx_data;
          nxt_st.hold_last = tx_last;
          nxt_st.hold_vld = 1'b1;
          nxt_st.tst = tx_last ? GPC_TX_IDLE : GPC_TX_SEND;
        end
        if (hd_eff && st_ff.crs_s && !st_ff.hold_vld) begin
          nxt_st.tx_rdy = 1'b0;
        end
      end
      GPC_TX_SEND: begin
        if (hd_eff && st_ff.col_s && st_ff.tx_en) begin
          // collision: drop the rest of the frame
          nxt_st.tst = GPC_TX_DRAIN;
          nxt_st.hold_vld = 1'b0;
        end else if (tx_valid && st_ff.tx_rdy) begin
          nxt_st.hold_d = tx_data;
          nxt_st.hold_last = tx_last;
          nxt_st.hold_vld = 1'b1;
          if (tx_last) begin
            nxt_st.tst = GPC_TX_IDLE;
          end
        end
      end
      GPC_TX_DRAIN: begin
        if (tx_valid && st_ff.tx_rdy && tx_last) begin
          nxt_st.tst = GPC_TX_IDLE;
        end
      end
      default: begin
        nxt_st.tst = GPC_TX_IDLE;
      end
    endcase

    // receiver activity follows lock in the PLL variant
    nxt_st.ract = lock_ok;

    // sample at each receive clock rising edge
    if (!lock_ok) begin
      nxt_st.pend_vld = 1'b0;
    end else if (rclk_rise) begin
      if (st_ff.pend_vld) begin
        nxt_st.push = 1'b1;
        nxt_st.push_w = rx_word(st_ff.pend_d, st_ff.pend_er,
            !rx_sample[GPC_RXW_LAST]);
      end
      nxt_st.pend_vld = rx_sample[GPC_RXW_LAST];
      nxt_st.pend_d = rx_sample[7:0];
      nxt_st.pend_er = rx_sample[GPC_RXW_ERR];
    end

    // a byte offered to a full buffer is lost and flagged
    if (st_ff.push && !fifo_in_ready) begin
      nxt_st.ovf = 1'b1;
    end
  end

  // state register, frozen while ce is low; one shared transmit clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // receive buffer towards the user stream
  gpc_fifo #(
    .WIDTH(GPC_RXW_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_data(st_ff.push_w),
    .in_valid(st_ff.push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(rx_ready)
  );

endmodule // gpc_gmii_phy_side

/* File: sim/gpc_gmii_phy_side_checker.sv */
/* port checks for the gigabit physical-side adapter
   assumes one clock domain and ce held high */
`timescale 1ns/100ps
module gpc_gmii_phy_side_checker #(
  parameter bit PLL_RX = 1'b0
) (
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire logic half_duplex, // duplex ask
  input wire logic [7:0] tx_data, // user byte
  input wire logic tx_valid, // byte present
  input wire logic tx_ready, // byte taken
  input wire logic [7:0] gmii_txd, // data pins
  input wire logic gmii_tx_en, // enable pin
  input wire logic gmii_tx_er, // error pin
  input wire logic gmii_tx_clk, // fwd clock
  input wire logic gmii_col, // col pin
  input wire logic gmii_crs, // crs pin
  input wire logic col_seen, // synced col
  input wire logic crs_seen, // synced crs
  input wire logic [7:0] rx_data, // rx byte
  input wire logic rx_valid, // rx present
  input wire logic rx_ready, // rx taken
  input wire logic rx_active, // rx running
  input wire logic hd_refused // hd refused
);
  // all checks on the one clock
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_col;
    $past(reset_n, 3) |-> col_seen == $past(gmii_col, 2);
  endproperty
  a_col: assert property (p_col) else $error("col sync off");
  property p_crs;
    $past(reset_n, 3) |-> crs_seen == $past(gmii_crs, 2);
  endproperty
  a_crs: assert property (p_crs) else $error("crs sync off");
  property p_fclk;
    $past(reset_n, 3) |-> gmii_tx_clk != $past(gmii_tx_clk);
  endproperty
  a_fclk: assert property (p_fclk) else $error("fwd clk stuck");
  property p_pins;
    $past(reset_n, 3) && !$stable({gmii_txd, gmii_tx_en, gmii_tx_er})
      |-> !gmii_tx_clk;
  endproperty
  a_pins: assert property (p_pins) else $error("pins off slot");
  property p_take;
    tx_ready && tx_valid && !half_duplex
      |-> ##3 gmii_tx_en && gmii_txd == $past(tx_data, 3);
  endproperty
  a_take: assert property (p_take) else $error("tx byte lost");
  property p_hd;
    $past(reset_n, 3) |-> hd_refused == ($past(half_duplex) && PLL_RX);
  endproperty
  a_hd: assert property (p_hd) else $error("hd refusal off");
  property p_rxhold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_rxhold: assert property (p_rxhold) else $error("rx dropped");
  property p_act;
    !PLL_RX && $past(reset_n, 5) |-> rx_active;
  endproperty
  a_act: assert property (p_act) else $error("rx inactive");
endmodule // gpc_gmii_phy_side_checker

bind gpc_gmii_phy_side gpc_gmii_phy_side_checker #(.PLL_RX(PLL_RX)) chk_u (
  .clk(clk), .reset_n(reset_n), .half_duplex(half_duplex),
  .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .gmii_txd(gmii_txd), .gmii_tx_en(gmii_tx_en), .gmii_tx_er(gmii_tx_er),
  .gmii_tx_clk(gmii_tx_clk), .gmii_col(gmii_col), .gmii_crs(gmii_crs),
  .col_seen(col_seen), .crs_seen(crs_seen), .rx_data(rx_data),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_active(rx_active),
  .hd_refused(hd_refused));

/* File: sim/gpc_phy_model.sv */
/* receive side of an external gigabit phy
   assumes the bench calls send and nothing else drives these pins */
`timescale 1ns/100ps
module gpc_phy_model (
  output logic rx_clk, // own receive clock
  output logic [7:0] rxd, // receive data
  output logic rx_dv, // data valid
  output logic rx_er // error
);
  // pins idle at start
  initial begin
    rx_clk = 1'b0;
    rxd = 8'h00;
    rx_dv = 1'b0;
    rx_er = 1'b0;
  end
  // private 160 ns receive clock, free running
  always #80 rx_clk = ~rx_clk;
  // one frame, bytes counting up, error flag on byte er_at
  task automatic send(input int n, input logic [7:0] first, input int er_at);
    for (int i = 0; i < n; i++) begin
      @(negedge rx_clk);
      rxd = first + 8'(i);
      rx_dv = 1'b1;
      rx_er = (i == er_at);
    end
    @(negedge rx_clk);
    rx_dv = 1'b0;
    rx_er = 1'b0;
    rxd = ~rxd; // stale data not held
  endtask
endmodule // gpc_phy_model

/* File: sim/gpc_gmii_phy_side_tb.sv */
/* self-checking bench for the gigabit physical-side adapter
   assumes the phy model on the receive pins, ce held high */
`timescale 1ns/100ps
module gpc_gmii_phy_side_tb import gpc_pkg::*;;
  logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, half_duplex = 1'b0;
  logic [7:0] tx_data = 8'h00, txd, rxd, rx_data;
  logic tx_valid = 1'b0, tx_last = 1'b0, tx_ready, tx_en, tx_er, tx_clk;
  logic col = 1'b0, crs = 1'b0, col_seen, crs_seen, rx_clk, dv, er;
  logic rx_err, rx_last, rx_valid, rx_ready = 1'b0, rx_active, ovf, hd;
  int fail_count = 0, samples_checked = 0, ovf_cnt = 0;
  logic [9:0] txq[$], rxq[$];

  // 50 MHz system clock
  always #10 clk = ~clk;

  gpc_phy_model phy_u (.rx_clk(rx_clk), .rxd(rxd), .rx_dv(dv), .rx_er(er));

  gpc_gmii_phy_side dut_u (.clk(clk), .reset_n(reset_n), .ce(ce),
    .half_duplex(half_duplex), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .gmii_txd(txd),
    .gmii_tx_en(tx_en), .gmii_tx_er(tx_er), .gmii_tx_clk(tx_clk),
    .gmii_col(col), .gmii_crs(crs), .col_seen(col_seen),
    .crs_seen(crs_seen), .gmii_rx_clk(rx_clk), .gmii_rxd(rxd),
    .gmii_rx_dv(dv), .gmii_rx_er(er), .rx_pll_locked(1'b0),
    .rx_data(rx_data), .rx_err(rx_err), .rx_last(rx_last),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_active(rx_active),
    .rx_overflow(ovf), .hd_refused(hd));

  // capture pins as the phy would, plus the user receive stream
  always @(posedge clk) begin
    if (reset_n && tx_clk && tx_en) txq.push_back({2'b00, txd});
    if (reset_n && rx_valid && rx_ready) rxq.push_back({rx_last, rx_err, rx_data});
    if (ovf === 1'b1) ovf_cnt++;
  end

  task automatic chk(input string what, input logic [9:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // offer one byte, hold it until the slot takes it
  task automatic tx_byte(input logic [7:0] d, input logic l);
    tx_data <= d;
    tx_valid <= 1'b1;
    tx_last <= l;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      if (tx_ready) break;
    end
  endtask

  task automatic t_tx();
    txq.delete();
    @(posedge clk);
    for (int i = 0; i < 4; i++) tx_byte(8'h5a + 8'(i), i == 3);
    tx_valid <= 1'b0;
    repeat (8) @(posedge clk);
    chk("tx count", 10'd4, 10'(txq.size()));
    foreach (txq[i]) chk("tx byte", 10'(8'h5a + i), txq[i]);
    chk("tx idle", 10'd0, 10'(tx_en));
    chk("tx err", 10'd0, 10'(tx_er));
    $display("test tx done");
  endtask

  task automatic t_sync();
    @(posedge clk);
    {col, crs} <= 2'b10;
    @(posedge clk);
    #1 chk("sync early", 10'd0, {8'h00, col_seen, crs_seen});
    @(posedge clk);
    #1 chk("col seen", 10'd2, {8'h00, col_seen, crs_seen});
    @(posedge clk);
    {col, crs} <= 2'b01;
    repeat (2) @(posedge clk);
    #1 chk("crs seen", 10'd1, {8'h00, col_seen, crs_seen});
    @(posedge clk);
    {col, crs} <= 2'b00;
    $display("test sync done");
  endtask

  task automatic t_rx();
    rxq.delete();
    phy_u.send(3, 8'ha0, 1);
    repeat (20) @(posedge clk);
    rx_ready <= 1'b1;
    repeat (10) @(posedge clk);
    chk("rx count", 10'd3, 10'(rxq.size()));
    foreach (rxq[i]) chk("rx word", {i == 2, i == 1, 8'(8'ha0 + i)}, rxq[i]);
    $display("test rx done");
  endtask

  task automatic t_ovf();
    @(posedge clk);
    rx_ready <= 1'b0;
    ovf_cnt = 0;
    rxq.delete();
    phy_u.send(GPC_FIFO_DEPTH + 4, 8'h10, 99);
    repeat (20) @(posedge clk);
    chk("overflow", 10'd1, 10'(ovf_cnt != 0));
    rx_ready <= 1'b1;
    repeat (40) @(posedge clk);
    chk("first kept", 10'h010, rxq[0]);
    chk("kept", 10'd1, 10'(rxq.size() >= GPC_FIFO_DEPTH));
    chk("empty", 10'd0, 10'(rx_valid));
    $display("test overflow done");
  endtask

  task automatic t_hd();
    @(posedge clk);
    half_duplex <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("hd refused", 10'd0, 10'(hd));
    chk("rx active", 10'd1, 10'(rx_active));
    @(posedge clk);
    half_duplex <= 1'b0;
    $display("test duplex done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_tx();
    t_sync();
    t_rx();
    t_ovf();
    t_hd();
    tally_and_finish();
  end

  // watchdog, far beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end
endmodule // gpc_gmii_phy_side_tb
